//--- verilog/io_status_indication_map.sv
// Function
// - Input n lands in bit n-1 of the input process byte.
// - Output byte bits 0..3 drive outputs 1..4; bits 4..7 unused.
// - 32-bit status word; bits 31..6 read as zero.
// - Status bits 0..3: output short, output overload, actuator short, actuator undervoltage.
// - Status bit 4 sensor supply overload, bit 5 sensor supply undervoltage.
// - Ready lamp green operational, yellow flashing on update, red if invalid.
// - Ready lamp flashes green/yellow on supply, temperature or actuator faults.
// - Green/yellow ready plus red sensor lamp signals sensor overload.
// - Bus-fault lamp steady red without comms, startup or no baud rate.
// - Bus-fault lamp flashes on unconfigured, mismatch, bad parameters, bad address.
// - Clear/stop gives safe outputs and flashing bus-fault; off when no error.
// - Group-error lamp red on diagnostics, hardware fault or data mismatch.
// - Sensor lamp green present, off absent or low, red overloaded.
// - Actuator lamp green when actuator voltage present, else off.
// - Each input lamp yellow while its input is set.
// - Output lamp yellow when set, red when set during short/overload, off otherwise.
// - Channel lamps indexed by process byte then bit position.
// - Two-bit substitute mode: low, high, hold last, per-channel values.
// - Only output writes retrigger watchdog; timeout applies substitutes, flags bus fault.
`timescale 1ns/100ps
`default_nettype none
`include "io_map_defs.svh"
module io_status_indication_map #(
    parameter int unsigned BLINK_HALF = `BLINK_HALF_CYCLES,
    parameter int unsigned WDOG_LIMIT = `WDOG_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] digital_input,
    input wire io_map_pkg::supply_fault_t faults,
    input wire io_map_pkg::bus_state_t bus_state,
    input wire logic out_write,
    input wire logic [7:0] out_data,
    input wire logic wdog_enable,
    input wire logic [1:0] subst_mode,
    input wire logic [3:0] subst_values,
    output logic [7:0] input_image_byte,
    output logic [7:0] output_image_byte,
    output logic [31:0] fault_status_word,
    output logic [3:0] digital_output,
    output logic wdog_expired,
    output io_map_pkg::lamp_color_t ready_lamp,
    output logic bus_fault_lamp,
    output logic group_error_lamp,
    output io_map_pkg::lamp_color_t sensor_supply_lamp,
    output logic actuator_supply_lamp,
    output logic [7:0] input_lamp,
    output io_map_pkg::lamp_color_t [3:0] output_lamp
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
logic [7:0] din_meta;
logic [7:0] din_sync;
io_map_pkg::supply_fault_t flt_meta;
io_map_pkg::supply_fault_t flt;
io_map_pkg::bus_state_t bus_meta;
io_map_pkg::bus_state_t bus;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        din_meta <= 8'h00;
        din_sync <= 8'h00;
        flt_meta <= '0;
        flt <= '0;
        bus_meta <= '0;
        bus <= '0;
    end else begin
        din_meta <= digital_input;
        din_sync <= din_meta;
        flt_meta <= faults;
        flt <= flt_meta;
        bus_meta <= bus_state;
        bus <= bus_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Blink timebase, shared so all flashing lamps stay in phase
logic [31:0] blink_cnt;
logic blink_phase;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        blink_cnt <= 32'h0;
        blink_phase <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF - 1) begin
        blink_cnt <= 32'h0;
        blink_phase <= ~blink_phase;
    end else begin
        blink_cnt <= blink_cnt + 32'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Process data watchdog
// Counting stops at expiry; only a reset, a write or a disable clears it
logic [31:0] wdog_cnt;
logic wdog_armed;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        wdog_cnt <= 32'h0;
        wdog_armed <= 1'b0;
        wdog_expired <= 1'b0;
    end else if (!wdog_enable) begin
        wdog_cnt <= 32'h0;
        wdog_armed <= 1'b0;
        wdog_expired <= 1'b0;
    end else if (out_write) begin
        wdog_cnt <= 32'h0;
        wdog_armed <= 1'b1;
        wdog_expired <= 1'b0;
    end else if (wdog_armed && !wdog_expired) begin
        if (wdog_cnt >= WDOG_LIMIT - 1) begin
            wdog_expired <= 1'b1;
        end else begin
            wdog_cnt <= wdog_cnt + 32'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Process images and outputs
logic safe_state;
logic [3:0] next_dout;
assign safe_state = wdog_expired | bus.clear_stop;

always_comb begin
    next_dout = output_image_byte[3:0];
    if (safe_state) begin
        case (subst_mode)
            `SUBST_ALL_LOW: next_dout = 4'h0;
            `SUBST_ALL_HIGH: next_dout = 4'hF;
            `SUBST_HOLD: next_dout = digital_output;
            `SUBST_CHANNEL: next_dout = subst_values;
            default: next_dout = 4'h0;
        endcase
    end
end

always_ff @(posedge clk) begin
    if (sys_rst) begin
        input_image_byte <= 8'h00;
        output_image_byte <= 8'h00;
        digital_output <= 4'h0;
    end else begin
        input_image_byte <= din_sync;
        if (out_write) begin
            output_image_byte <= out_data;
        end
        digital_output <= next_dout;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status word
always_ff @(posedge clk) begin
    if (sys_rst) begin
        fault_status_word <= 32'h0;
    end else begin
        fault_status_word <= {26'h0,
            flt.sens_under, flt.sens_ovld,
            flt.act_under, flt.act_short, flt.out_ovld, flt.out_short};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Lamps
logic ready_alarm;
assign ready_alarm = flt.sens_under | flt.sens_over | flt.sens_ovld | flt.over_temp
                   | !flt.act_present | flt.act_surge | flt.act_under | flt.act_short;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        ready_lamp <= io_map_pkg::LAMP_RED;
    end else if (flt.addr_invalid || flt.not_ready) begin
        ready_lamp <= io_map_pkg::LAMP_RED;
    end else if (flt.fw_update) begin
        ready_lamp <= blink_phase ? io_map_pkg::LAMP_YELLOW : io_map_pkg::LAMP_OFF;
    end else if (ready_alarm) begin
        ready_lamp <= blink_phase ? io_map_pkg::LAMP_YELLOW : io_map_pkg::LAMP_GREEN;
    end else begin
        ready_lamp <= io_map_pkg::LAMP_GREEN;
    end
end

always_ff @(posedge clk) begin
    if (sys_rst) begin
        bus_fault_lamp <= 1'b1;
    end else if (bus.no_comm || bus.starting || bus.no_baud) begin
        bus_fault_lamp <= 1'b1;
    end else if (bus.not_configured || bus.cfg_mismatch || bus.bad_params || bus.bad_address
                 || bus.clear_stop || wdog_expired) begin
        bus_fault_lamp <= blink_phase;
    end else begin
        bus_fault_lamp <= 1'b0;
    end
end

always_ff @(posedge clk) begin
    if (sys_rst) begin
        group_error_lamp <= 1'b0;
        sensor_supply_lamp <= io_map_pkg::LAMP_OFF;
        actuator_supply_lamp <= 1'b0;
        input_lamp <= 8'h00;
    end else begin
        group_error_lamp <= bus.diag_present | bus.hw_fault | bus.data_mismatch
                          | (|fault_status_word[`STAT_USED_BITS-1:0]);
        if (flt.sens_ovld) begin
            sensor_supply_lamp <= io_map_pkg::LAMP_RED;
        end else if (flt.sens_present && !flt.sens_under) begin
            sensor_supply_lamp <= io_map_pkg::LAMP_GREEN;
        end else begin
            sensor_supply_lamp <= io_map_pkg::LAMP_OFF;
        end
        actuator_supply_lamp <= flt.act_present;
        input_lamp <= din_sync;
    end
end

// Fault inputs are device-wide, so every set output shows red on an output short or overload fault
always_ff @(posedge clk) begin
    if (sys_rst) begin
        output_lamp <= '{default: io_map_pkg::LAMP_OFF};
    end else begin
        for (int i = 0; i < 4; i++) begin
            if (next_dout[i] && (flt.out_short || flt.out_ovld)) begin
                output_lamp[i] <= io_map_pkg::LAMP_RED;
            end else if (next_dout[i]) begin
                output_lamp[i] <= io_map_pkg::LAMP_YELLOW;
            end else begin
                output_lamp[i] <= io_map_pkg::LAMP_OFF;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Assertions
property p_in_map;
    @(posedge clk) disable iff (sys_rst) input_image_byte == $past(din_sync);
endproperty
a_in_map: assert property (p_in_map) else $error("input byte mismatch");

property p_out_map;
    @(posedge clk) disable iff (sys_rst) !$past(safe_state) |-> digital_output == $past(output_image_byte[3:0]);
endproperty
a_out_map: assert property (p_out_map) else $error("output drive mismatch");

property p_reserved;
    @(posedge clk) disable iff (sys_rst) fault_status_word[31:6] == 26'h0;
endproperty
a_reserved: assert property (p_reserved) else $error("reserved status bits set");

property p_stat_low;
    @(posedge clk) disable iff (sys_rst)
        fault_status_word[3:0] == $past({flt.act_under, flt.act_short, flt.out_ovld, flt.out_short});
endproperty
a_stat_low: assert property (p_stat_low) else $error("status bits 0-3 wrong");

property p_stat_sens;
    @(posedge clk) disable iff (sys_rst) fault_status_word[5:4] == $past({flt.sens_under, flt.sens_ovld});
endproperty
a_stat_sens: assert property (p_stat_sens) else $error("status bits 4-5 wrong");

property p_subst_low;
    @(posedge clk) disable iff (sys_rst) $past(safe_state) && $past(subst_mode) == `SUBST_ALL_LOW |-> digital_output == 4'h0;
endproperty
a_subst_low: assert property (p_subst_low) else $error("substitute low not applied");

property p_subst_ch;
    @(posedge clk) disable iff (sys_rst) $past(safe_state) && $past(subst_mode) == `SUBST_CHANNEL |-> digital_output == $past(subst_values);
endproperty
a_subst_ch: assert property (p_subst_ch) else $error("channel substitutes not applied");

property p_bus_lamp_steady;
    @(posedge clk) disable iff (sys_rst) $past(bus.no_comm) |-> bus_fault_lamp;
endproperty
a_bus_lamp_steady: assert property (p_bus_lamp_steady) else $error("bus fault lamp not lit");

property p_act_lamp;
    @(posedge clk) disable iff (sys_rst) actuator_supply_lamp == $past(flt.act_present);
endproperty
a_act_lamp: assert property (p_act_lamp) else $error("actuator lamp wrong");

property p_sens_red;
    @(posedge clk) disable iff (sys_rst) $past(flt.sens_ovld) |-> sensor_supply_lamp == io_map_pkg::LAMP_RED;
endproperty
a_sens_red: assert property (p_sens_red) else $error("sensor lamp not red on overload");

property p_wd_retrig;
    @(posedge clk) disable iff (sys_rst) wdog_enable && out_write ##1 wdog_enable |-> !wdog_expired;
endproperty
a_wd_retrig: assert property (p_wd_retrig) else $error("write did not retrigger watchdog");

c_expire: cover property (@(posedge clk) disable iff (sys_rst) $rose(wdog_expired));
c_blink: cover property (@(posedge clk) disable iff (sys_rst) $rose(blink_phase));
c_red_out: cover property (@(posedge clk) disable iff (sys_rst) output_lamp[0] == io_map_pkg::LAMP_RED);

endmodule : io_status_indication_map
`default_nettype wire

//--- verilog/io_map_defs.svh
`ifndef IO_MAP_DEFS_SVH
`define IO_MAP_DEFS_SVH
`define STAT_OUT_SHORT 0
`define STAT_OUT_OVLD 1
`define STAT_ACT_SHORT 2
`define STAT_ACT_UNDER 3
`define STAT_SENS_OVLD 4
`define STAT_SENS_UNDER 5
`define STAT_USED_BITS 6
`define SUBST_ALL_LOW 2'h0
`define SUBST_ALL_HIGH 2'h1
`define SUBST_HOLD 2'h2
`define SUBST_CHANNEL 2'h3
`define BLINK_PERIOD_NS 500000000
`define CLK_PERIOD_NS 25
`define BLINK_HALF_CYCLES (`BLINK_PERIOD_NS / `CLK_PERIOD_NS / 2)
`define WDOG_TIMEOUT_NS 100000000
`define WDOG_CYCLES (`WDOG_TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

//--- verilog/io_map_pkg.sv
`default_nettype none
package io_map_pkg;
    typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_YELLOW, LAMP_RED} lamp_color_t;
    typedef struct packed {
        logic out_short;
        logic out_ovld;
        logic act_short;
        logic act_under;
        logic sens_ovld;
        logic sens_under;
        logic sens_over;
        logic act_present;
        logic act_surge;
        logic sens_present;
        logic over_temp;
        logic fw_update;
        logic addr_invalid;
        logic not_ready;
    } supply_fault_t;
    typedef struct packed {
        logic no_comm;
        logic starting;
        logic no_baud;
        logic not_configured;
        logic cfg_mismatch;
        logic bad_params;
        logic bad_address;
        logic clear_stop;
        logic diag_present;
        logic hw_fault;
        logic data_mismatch;
    } bus_state_t;
endpackage : io_map_pkg
`default_nettype wire

//--- verif/master_model.sv
`timescale 1ns/100ps
`default_nettype none
module master_model (
    input wire logic clk,
    input wire logic send,
    input wire logic [7:0] data,
    output var logic out_write,
    output var logic [7:0] out_data
);
    // One-cycle strobe; between writes the data lines show the inverse so a stale byte never passes
    always @(posedge clk) begin
        out_write <= send;
        out_data <= send ? {4'h0, data[3:0]} : ~{4'h0, data[3:0]};
    end
endmodule : master_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int BH = 4;
    localparam int WL = 16;
    localparam io_map_pkg::lamp_color_t O = io_map_pkg::LAMP_OFF;
    localparam io_map_pkg::lamp_color_t G = io_map_pkg::LAMP_GREEN;
    localparam io_map_pkg::lamp_color_t Y = io_map_pkg::LAMP_YELLOW;
    localparam io_map_pkg::lamp_color_t R = io_map_pkg::LAMP_RED;
    localparam io_map_pkg::supply_fault_t OK_F = 14'h0050; // Both supplies present, no fault
    logic clk, sys_rst, send, out_write, wdog_enable, wdog_expired;
    logic bus_fault_lamp, group_error_lamp, actuator_supply_lamp;
    logic [7:0] digital_input, data, out_data, input_image_byte, output_image_byte, input_lamp;
    logic [31:0] fault_status_word;
    logic [3:0] digital_output, subst_values;
    logic [1:0] subst_mode;
    io_map_pkg::supply_fault_t faults;
    io_map_pkg::bus_state_t bus_state;
    io_map_pkg::lamp_color_t ready_lamp, sensor_supply_lamp;
    io_map_pkg::lamp_color_t [3:0] output_lamp;
    int n_errors = 0;
    int compares = 0;
////////////////////////////////////////////////////////////////////////
    master_model partner (.clk(clk), .send(send), .data(data), .out_write(out_write), .out_data(out_data));
    io_status_indication_map #(.BLINK_HALF(BH), .WDOG_LIMIT(WL)) dut (
        .clk(clk), .sys_rst(sys_rst), .digital_input(digital_input), .faults(faults),
        .bus_state(bus_state), .out_write(out_write), .out_data(out_data), .wdog_enable(wdog_enable),
        .subst_mode(subst_mode), .subst_values(subst_values), .input_image_byte(input_image_byte),
        .output_image_byte(output_image_byte), .fault_status_word(fault_status_word),
        .digital_output(digital_output), .wdog_expired(wdog_expired), .ready_lamp(ready_lamp),
        .bus_fault_lamp(bus_fault_lamp), .group_error_lamp(group_error_lamp),
        .sensor_supply_lamp(sensor_supply_lamp), .actuator_supply_lamp(actuator_supply_lamp),
        .input_lamp(input_lamp), .output_lamp(output_lamp));
////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] v);
        @(posedge clk);
        send <= 1'b1;
        data <= v;
        @(posedge clk);
        send <= 1'b0;
    endtask : wr
    // Both colours must appear within two blink periods plus four cycles
    task automatic blink(input int sel, input logic [1:0] a, input logic [1:0] b);
        logic sa, sb;
        logic [1:0] v;
        sa = 1'b0;
        sb = 1'b0;
        repeat (4 * BH + 4) begin
            @(posedge clk);
            v = sel ? {1'b0, bus_fault_lamp} : ready_lamp;
            sa |= (v === a);
            sb |= (v === b);
        end
        chk({sa, sb}, 2'h3);
    endtask : blink
    task automatic complete_run;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
////////////////////////////////////////////////////////////////////////
    task automatic t_inputs;
        logic [7:0] p[3] = '{8'h01, 8'h80, 8'hA5};
        for (int i = 0; i < 3; i++) begin
            digital_input <= p[i];
            cyc(6);
            chk(input_image_byte, p[i]);
            chk(input_lamp, p[i]);
        end
        $display("test inputs done");
    endtask : t_inputs
    task automatic t_outputs;
        wr(8'h05);
        cyc(4);
        chk(output_image_byte, 8'h05);
        chk(digital_output, 4'h5);
        chk(output_lamp, {O, Y, O, Y});
        faults <= OK_F | 14'h2000;
        cyc(6);
        chk(output_lamp, {O, R, O, R});
        $display("test outputs done");
    endtask : t_outputs
    task automatic t_status;
        for (int i = 0; i < 6; i++) begin
            faults <= OK_F | (14'h2000 >> i);
            cyc(6);
            chk(fault_status_word, 32'h1 << i);
            chk(group_error_lamp, 1'b1);
        end
        $display("test status done");
    endtask : t_status
    task automatic t_lamps;
        logic [13:0] rf[5] = '{14'h0001, 14'h0002, 14'h0008, 14'h0004, 14'h0200};
        io_map_pkg::lamp_color_t ra[5] = '{R, R, G, Y, G};
        io_map_pkg::lamp_color_t rb[5] = '{R, R, Y, O, Y};
        faults <= OK_F;
        cyc(6);
        chk(ready_lamp, G);
        chk(bus_fault_lamp, 1'b0);
        chk(group_error_lamp, 1'b0);
        chk(sensor_supply_lamp, G);
        chk(actuator_supply_lamp, 1'b1);
        faults <= OK_F & ~14'h0050;
        cyc(6);
        chk(sensor_supply_lamp, O);
        chk(actuator_supply_lamp, 1'b0);
        for (int i = 0; i < 5; i++) begin
            faults <= OK_F | rf[i];
            cyc(6);
            blink(0, ra[i], rb[i]);
        end
        chk(sensor_supply_lamp, R);
        faults <= OK_F;
        for (int i = 0; i < 11; i++) begin
            bus_state <= 11'h400 >> i;
            cyc(6);
            if (i < 3) begin
                chk(bus_fault_lamp, 1'b1);
                cyc(BH + 1);
                chk(bus_fault_lamp, 1'b1);
            end else if (i < 8) begin
                blink(1, 2'h1, 2'h0);
            end else begin
                chk(group_error_lamp, 1'b1);
            end
            if (i == 7)
                chk(digital_output, 4'h0);
        end
        bus_state <= '0;
        $display("test lamps done");
    endtask : t_lamps
    task automatic t_subst;
        logic [3:0] e[4] = '{4'h0, 4'hF, 4'h5, 4'hA};
        wdog_enable <= 1'b1;
        subst_values <= 4'hA;
        for (int m = 0; m < 4; m++) begin
            subst_mode <= m[1:0];
            wr(8'h05);
            cyc(WL / 2);
            chk(wdog_expired, 1'b0);
            cyc(WL + 4);
            chk(wdog_expired, 1'b1);
            chk(digital_output, e[m]);
            blink(1, 2'h1, 2'h1);
        end
        wr(8'h03);
        cyc(4);
        chk(wdog_expired, 1'b0);
        wdog_enable <= 1'b0;
        $display("test substitute done");
    endtask : t_subst
////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Cycle budget well above the sum of all tests
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    initial begin
        sys_rst = 1'b1;
        send = 1'b0;
        data = 8'h00;
        digital_input = 8'h00;
        faults = OK_F;
        bus_state = '0;
        wdog_enable = 1'b0;
        subst_mode = 2'h0;
        subst_values = 4'h0;
        cyc(2);
        sys_rst <= 1'b0;
        cyc(4);
        t_inputs();
        t_outputs();
        t_status();
        t_lamps();
        t_subst();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
